/* dv/relay_bank.sv */
// Relay bank model wired to the four output terminals
`timescale 1ns/1ps
module relay_bank (
   // Coil drive from the terminals
   input  wire logic       coilOne,
   input  wire logic       coilTwo,
   input  wire logic       coilThree,
   input  wire logic       coilFour,
   // Contact state, 1 = closed
   output logic [3:0]      contacts
);
   // Bounce is not modelled, so checks see the coil state at once
   assign contacts = {coilFour, coilThree, coilTwo, coilOne};
endmodule

/* dv/tb.sv */
// Self-checking bench for the output terminal function selector
`timescale 1ns/1ps
module tb;
   logic                             sys_clk = 1'h0;
   logic                             nrst = 1'h0;
   logic [3:0][7:0]                  codes = {4{8'h32}};
   logic [3:0]                       mask = 4'h0;
   logic [7:0]                       src = 8'h00;
   output_select_pkg::drive_status_s stat = '0;
   logic [15:0]                      freq = 16'h0064;
   logic [15:0]                      spd = 16'h0064;
   logic [15:0]                      fthr = 16'h0064;
   logic [15:0]                      sthr = 16'h0064;
   logic                             canWrEn = 1'h0;
   logic [7:0]                       canWrData = 8'h00;
   logic [7:0]                       canRdData;
   logic [15:0]                      serAddr = 16'h0000;
   logic                             serWrEn = 1'h0;
   logic                             serRdEn = 1'h0;
   logic [15:0]                      serWrData = 16'h0000;
   logic [15:0]                      serRdData;
   logic                             serRdValid;
   logic [3:0]                       outs;
   logic [3:0]                       contacts;
   logic [59:0]                      r;
   int                               n_mismatch = 0;
   int                               checked = 0;
   // Row: code, source, status, frequency, speed, expected
   localparam logic [59:0] ROWS [43] = '{
      60'h00_0_3FF_0064_0064_0, 60'h01_0_200_0064_0064_1,
      60'h01_0_000_0064_0064_0, 60'h16_0_080_0064_0064_1,
      60'h16_0_37F_0064_0064_0, 60'h17_0_040_0064_0064_1,
      60'h17_0_3BF_0064_0064_0, 60'h18_1_000_0064_0064_1,
      60'h18_0_3FF_0064_0064_0, 60'h19_0_100_0064_0064_1,
      60'h19_0_000_0064_0064_0, 60'h1A_0_000_0064_0064_1,
      60'h1A_0_100_0064_0064_0, 60'h1D_0_000_0064_0064_1,
      60'h1D_0_000_0063_0064_0, 60'h1E_0_000_0063_0064_1,
      60'h1E_0_000_0064_0064_0, 60'h21_0_200_0000_0064_1,
      60'h21_0_000_0000_0064_0, 60'h21_0_200_0001_0064_0,
      60'h22_0_000_0005_0064_1, 60'h22_0_200_0005_0064_0,
      60'h22_0_200_0000_0064_1, 60'h23_0_001_0064_0064_1,
      60'h24_0_002_0064_0064_1, 60'h25_0_004_0064_0064_1,
      60'h26_0_008_0064_0064_1, 60'h26_0_3F7_0064_0064_0,
      60'h28_0_220_0064_0064_1, 60'h28_0_000_0064_0064_1,
      60'h28_0_200_0064_0064_0, 60'h2B_0_000_0064_0063_1,
      60'h2B_0_000_0064_0064_0, 60'h2E_0_010_0064_0064_1,
      60'h2E_0_3EF_0064_0064_0, 60'h4B_0_300_0064_0064_1,
      60'h4B_0_100_0064_0064_0, 60'h4B_0_200_0064_0064_0,
      60'h4C_0_200_0064_0064_1, 60'h4C_0_300_0064_0064_0,
      60'h4C_0_000_0064_0064_0, 60'h2C_0_3FF_0000_0000_0,
      60'h02_0_3FF_0064_0064_0};

   output_terminal_function_select i_output_terminal_function_select (
      .sys_clk(sys_clk), .nrst(nrst),
      .outputOneFunctionCode(codes[0]), .outputTwoFunctionCode(codes[1]),
      .outputThreeFunctionCode(codes[2]), .outputFourFunctionCode(codes[3]),
      .outputInversionMask(mask), .runCommandSourceSetting(src),
      .frequencyThresholdSetting(fthr), .motorSpeedThresholdSetting(sthr),
      .driveStatus(stat), .actualFrequency(freq), .actualMotorSpeed(spd),
      .canWrEn(canWrEn), .canWrData(canWrData), .canRdData(canRdData),
      .serAddr(serAddr), .serWrEn(serWrEn), .serRdEn(serRdEn), .serWrData(serWrData),
      .serRdData(serRdData), .serRdValid(serRdValid),
      .digitalOutOne(outs[0]), .digitalOutTwo(outs[1]),
      .digitalOutThree(outs[2]), .digitalOutFour(outs[3]));

   relay_bank i_relay_bank (.coilOne(outs[0]), .coilTwo(outs[1]), .coilThree(outs[2]),
      .coilFour(outs[3]), .contacts(contacts));

   always #2 sys_clk = ~sys_clk;

   task automatic step(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s", $time, m);
      end
   endtask

   // One-cycle strobe; callers let a clock edge pass before the next call
   task automatic ser(input logic [15:0] a, input logic [15:0] d, input logic wr);
      serAddr = a;
      serWrData = d;
      serWrEn = wr;
      serRdEn = !wr;
      step(1);
      serWrEn = 1'h0;
      serRdEn = 1'h0;
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #40000;
      n_mismatch++;
      $display("BAD %0t watchdog expired", $time);
      finish_test();
   end

   initial begin
      step(20);
      chk({12'h000, contacts}, 16'h0000, "terminals in reset");
      chk({8'h00, canRdData}, 16'h000F, "object in reset");
      chk({15'h0000, serRdValid}, 16'h0000, "read valid in reset");
      nrst = 1'h1;
      step(2);
      chk({12'h000, contacts}, 16'h000F, "object initial bits");
      canWrEn = 1'h1;
      canWrData = 8'h02;
      step(1);
      canWrData = 8'h05;
      step(1);
      canWrEn = 1'h0;
      step(1);
      chk({12'h000, contacts}, 16'h0005, "object mapping");
      chk({8'h00, canRdData}, 16'h0005, "object readback");
      codes = {4{8'h33}};
      ser(16'h2640, 16'h0008, 1'h1);
      step(1);
      chk({12'h000, contacts}, 16'h0008, "serial mapping");
      ser(16'h2641, 16'hFFFF, 1'h1);
      step(1);
      chk({12'h000, contacts}, 16'h0008, "stray write taken");
      ser(16'h2640, 16'h0000, 1'h0);
      chk({15'h0000, serRdValid}, 16'h0001, "read valid");
      chk(serRdData, 16'h0008, "read data");
      step(1);
      chk({15'h0000, serRdValid}, 16'h0000, "read valid stuck");
      ser(16'h2641, 16'h0000, 1'h0);
      chk(serRdData, 16'h0000, "stray read data");
      for (int i = 0; i < 43; i++) begin
         r = ROWS[i];
         codes = {4{r[59:52]}};
         mask = i[3:0];
         src = {4'h0, r[51:48]};
         stat = r[45:36];
         freq = r[35:20];
         spd = r[19:4];
         step(2);
         chk({12'h000, contacts}, {12'h000, {4{r[0]}} ^ mask}, $sformatf("row %0d", i));
      end
      // Threshold settings move the compare points
      codes = {8'h2B, 8'h2B, 8'h1E, 8'h1D};
      mask = 4'h0;
      fthr = 16'h0065;
      sthr = 16'h0065;
      step(2);
      chk({12'h000, contacts}, 16'h000E, "thresholds raised");
      fthr = 16'h0010;
      sthr = 16'h0010;
      step(2);
      chk({12'h000, contacts}, 16'h0001, "thresholds lowered");
      // A reset in mid-run restores both override words
      nrst = 1'h0;
      #1;
      chk({12'h000, contacts}, 16'h0000, "terminals in second reset");
      chk({8'h00, canRdData}, 16'h000F, "object in second reset");
      step(1);
      nrst = 1'h1;
      codes = {8'h33, 8'h32, 8'h16, 8'h01};
      mask = 4'h0;
      stat = 10'h200;
      freq = 16'h0064;
      step(2);
      chk({12'h000, contacts}, 16'h0005, "separate selectors");
      mask = 4'h2;
      step(2);
      chk({12'h000, contacts}, 16'h0007, "single bit inversion");
      finish_test();
   end
endmodule

/* logic/function_select.sv */
// Per-terminal function code decoder
`timescale 1ns/1ps
module function_select (
   // Selection
   input  wire logic [7:0]                code,
   input  wire output_select_pkg::cond_s  cond,
   // Override bits for this terminal
   input  wire logic                      canBit,
   input  wire logic                      serBit,
   // Result before inversion
   output logic                           active
);

   function automatic logic decodeFunction(input logic [7:0] c,
                                           input output_select_pkg::cond_s k,
                                           input logic cb, input logic sb);
      logic r;
      r = 1'h0;
      case (c)
         output_select_pkg::FN_NONE:          r = 1'h0;
         output_select_pkg::FN_RUN:           r = k.runInd;
         output_select_pkg::FN_OC_STALL:      r = k.ocStall;
         output_select_pkg::FN_OV_STALL:      r = k.ovStall;
         output_select_pkg::FN_OP_SOURCE:     r = k.remoteSrc;
         output_select_pkg::FN_FWD_CMD:       r = k.fwdCmd;
         output_select_pkg::FN_REV_CMD:       r = k.revCmd;
         output_select_pkg::FN_FREQ_GE:       r = k.freqGe;
         output_select_pkg::FN_FREQ_LT:       r = k.freqLt;
         output_select_pkg::FN_ZERO_RUN:      r = k.zeroRun;
         output_select_pkg::FN_ZERO_STOP:     r = k.zeroStop;
         output_select_pkg::FN_ERR_ONE:       r = k.errSel[0];
         output_select_pkg::FN_ERR_TWO:       r = k.errSel[1];
         output_select_pkg::FN_ERR_THREE:     r = k.errSel[2];
         output_select_pkg::FN_ERR_FOUR:      r = k.errSel[3];
         output_select_pkg::FN_SPEED_REACHED: r = k.speedReached;
         output_select_pkg::FN_MOTOR_SLOW:    r = k.motorSlow;
         output_select_pkg::FN_DECEL_BACKUP:  r = k.decelBackup;
         output_select_pkg::FN_CANOPEN:       r = cb;
         output_select_pkg::FN_SERIAL:        r = sb;
         output_select_pkg::FN_FWD_RUN:       r = k.fwdRun;
         output_select_pkg::FN_REV_RUN:       r = k.revRun;
         default:                             r = 1'h0;
      endcase
      return r;
   endfunction

   always_comb begin
      active = decodeFunction(code, cond, canBit, serBit);
   end

endmodule

/* logic/output_select_pkg.sv */
// Constants, function codes and carrier types for the output terminal selector
package output_select_pkg;

   localparam int          NUM_OUT          = 4;
   localparam int          CODE_W           = 8;
   localparam int          FREQ_W           = 16;
   localparam int          SER_WORD_W       = 16;
   localparam int          CAN_OBJ_W        = 8;

   localparam logic [7:0]  FN_NONE          = 8'h00;
   localparam logic [7:0]  FN_RUN           = 8'h01;
   localparam logic [7:0]  FN_OC_STALL      = 8'h16;
   localparam logic [7:0]  FN_OV_STALL      = 8'h17;
   localparam logic [7:0]  FN_OP_SOURCE     = 8'h18;
   localparam logic [7:0]  FN_FWD_CMD       = 8'h19;
   localparam logic [7:0]  FN_REV_CMD       = 8'h1A;
   localparam logic [7:0]  FN_FREQ_GE       = 8'h1D;
   localparam logic [7:0]  FN_FREQ_LT       = 8'h1E;
   localparam logic [7:0]  FN_ZERO_RUN      = 8'h21;
   localparam logic [7:0]  FN_ZERO_STOP     = 8'h22;
   localparam logic [7:0]  FN_ERR_ONE       = 8'h23;
   localparam logic [7:0]  FN_ERR_TWO       = 8'h24;
   localparam logic [7:0]  FN_ERR_THREE     = 8'h25;
   localparam logic [7:0]  FN_ERR_FOUR      = 8'h26;
   localparam logic [7:0]  FN_SPEED_REACHED = 8'h28;
   localparam logic [7:0]  FN_MOTOR_SLOW    = 8'h2B;
   localparam logic [7:0]  FN_DECEL_BACKUP  = 8'h2E;
   localparam logic [7:0]  FN_CANOPEN       = 8'h32;
   localparam logic [7:0]  FN_SERIAL        = 8'h33;
   localparam logic [7:0]  FN_FWD_RUN       = 8'h4B;
   localparam logic [7:0]  FN_REV_RUN       = 8'h4C;

   localparam logic [15:0] SER_OVERRIDE_ADDR = 16'h2640;
   localparam logic [15:0] SER_WORD_RST      = 16'h0000;
   localparam logic [7:0]  CAN_OBJ_RST       = 8'h0F;
   localparam logic [3:0]  OUT_RST           = 4'h0;
   localparam logic [1:0]  CHK_READY_CNT     = 2'h3;

   typedef struct packed {
      logic       running;
      logic       dirForward;
      logic       ocStall;
      logic       ovStall;
      logic       freqReached;
      logic       decelBackup;
      logic [3:0] errSel;
   } drive_status_s;

   typedef struct packed {
      logic       runInd;
      logic       ocStall;
      logic       ovStall;
      logic       remoteSrc;
      logic       fwdCmd;
      logic       revCmd;
      logic       freqGe;
      logic       freqLt;
      logic       zeroRun;
      logic       zeroStop;
      logic [3:0] errSel;
      logic       speedReached;
      logic       motorSlow;
      logic       decelBackup;
      logic       fwdRun;
      logic       revRun;
   } cond_s;

   localparam cond_s COND_RST = '0;

endpackage

/* logic/output_terminal_function_select.sv */
// Output terminal function selector: condition staging, override words, outputs
`timescale 1ns/1ps
module output_terminal_function_select (
   // Clock and reset
   input  wire logic                             sys_clk,
   input  wire logic                             nrst,
   // Terminal configuration
   input  wire logic [7:0]                       outputOneFunctionCode,
   input  wire logic [7:0]                       outputTwoFunctionCode,
   input  wire logic [7:0]                       outputThreeFunctionCode,
   input  wire logic [7:0]                       outputFourFunctionCode,
   input  wire logic [3:0]                       outputInversionMask,
   // Drive settings
   input  wire logic [7:0]                       runCommandSourceSetting,
   input  wire logic [15:0]                      frequencyThresholdSetting,
   input  wire logic [15:0]                      motorSpeedThresholdSetting,
   // Drive state
   input  wire output_select_pkg::drive_status_s driveStatus,
   input  wire logic [15:0]                      actualFrequency,
   input  wire logic [15:0]                      actualMotorSpeed,
   // CANopen output object
   input  wire logic                             canWrEn,
   input  wire logic [7:0]                       canWrData,
   output logic [7:0]                            canRdData,
   // Serial register access
   input  wire logic [15:0]                      serAddr,
   input  wire logic                             serWrEn,
   input  wire logic                             serRdEn,
   input  wire logic [15:0]                      serWrData,
   output logic [15:0]                           serRdData,
   output logic                                  serRdValid,
   // Terminals
   output logic                                  digitalOutOne,
   output logic                                  digitalOutTwo,
   output logic                                  digitalOutThree,
   output logic                                  digitalOutFour
);

   output_select_pkg::cond_s condQ;
   logic [15:0]              serWordQ;
   logic [7:0]               canObjQ;
   logic [3:0]               outQ;
   logic [3:0]               selActive;
   logic [7:0]               codeVec [4];
   logic                     serHit;
   logic [15:0]              serRdDataQ;
   logic                     serRdValidQ;
   logic [7:0]               canRdDataQ;
   logic [1:0]               chkCntQ;
   logic                     chkReady;

   assign codeVec[0] = outputOneFunctionCode;
   assign codeVec[1] = outputTwoFunctionCode;
   assign codeVec[2] = outputThreeFunctionCode;
   assign codeVec[3] = outputFourFunctionCode;

   assign serHit = (serAddr == output_select_pkg::SER_OVERRIDE_ADDR);

   // Condition staging: one register level keeps the comparators off the output path
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         condQ <= output_select_pkg::COND_RST;
      end else begin
         condQ.runInd       <= driveStatus.running;
         condQ.ocStall      <= driveStatus.ocStall;
         condQ.ovStall      <= driveStatus.ovStall;
         condQ.remoteSrc    <= (runCommandSourceSetting != 8'h00);
         condQ.fwdCmd       <= driveStatus.dirForward;
         condQ.revCmd       <= !driveStatus.dirForward;
         condQ.freqGe       <= (actualFrequency >= frequencyThresholdSetting);
         condQ.freqLt       <= (actualFrequency < frequencyThresholdSetting);
         condQ.zeroRun      <= driveStatus.running && (actualFrequency == 16'h0000);
         condQ.zeroStop     <= !driveStatus.running || (actualFrequency == 16'h0000);
         condQ.errSel       <= driveStatus.errSel;
         condQ.speedReached <= driveStatus.freqReached || !driveStatus.running;
         condQ.motorSlow    <= (actualMotorSpeed < motorSpeedThresholdSetting);
         condQ.decelBackup  <= driveStatus.decelBackup;
         condQ.fwdRun       <= driveStatus.running && driveStatus.dirForward;
         condQ.revRun       <= driveStatus.running && !driveStatus.dirForward;
      end
   end

   override_word_reg #(
      .W   (output_select_pkg::CAN_OBJ_W),
      .RST (output_select_pkg::CAN_OBJ_RST)
   ) canObj (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .wrEn    (canWrEn),
      .wrData  (canWrData),
      .word_q  (canObjQ)
   );

   override_word_reg #(
      .W   (output_select_pkg::SER_WORD_W),
      .RST (output_select_pkg::SER_WORD_RST)
   ) serWord (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .wrEn    (serWrEn && serHit),
      .wrData  (serWrData),
      .word_q  (serWordQ)
   );

   // Unmapped serial reads answer zero so a stray poll never sees stale data
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         serRdDataQ  <= output_select_pkg::SER_WORD_RST;
         serRdValidQ <= 1'h0;
      end else begin
         serRdValidQ <= serRdEn;
         if (serRdEn && serHit) begin
            serRdDataQ <= serWordQ;
         end else if (serRdEn) begin
            serRdDataQ <= 16'h0000;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         canRdDataQ <= output_select_pkg::CAN_OBJ_RST;
      end else begin
         canRdDataQ <= canObjQ;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < output_select_pkg::NUM_OUT; gi++) begin : gSel
         function_select sel (
            .code   (codeVec[gi]),
            .cond   (condQ),
            .canBit (canObjQ[gi]),
            .serBit (serWordQ[gi]),
            .active (selActive[gi])
         );
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         outQ <= output_select_pkg::OUT_RST;
      end else begin
         outQ <= selActive ^ outputInversionMask;
      end
   end

   assign digitalOutOne   = outQ[0];
   assign digitalOutTwo   = outQ[1];
   assign digitalOutThree = outQ[2];
   assign digitalOutFour  = outQ[3];
   assign serRdData       = serRdDataQ;
   assign serRdValid      = serRdValidQ;
   assign canRdData       = canRdDataQ;

   // Checks wait until the two-stage pipe holds post-reset data
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         chkCntQ <= 2'h0;
      end else if (chkCntQ != output_select_pkg::CHK_READY_CNT) begin
         chkCntQ <= chkCntQ + 2'h1;
      end
   end

   assign chkReady = (chkCntQ == output_select_pkg::CHK_READY_CNT);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   oc_stall_sel_a: assert property (
      chkReady && $past(outputOneFunctionCode) == output_select_pkg::FN_OC_STALL
      |-> digitalOutOne == ($past(driveStatus.ocStall, 2) ^ $past(outputInversionMask[0])))
      else $error("over-current stall not on output one");

   ov_stall_sel_a: assert property (
      chkReady && $past(outputTwoFunctionCode) == output_select_pkg::FN_OV_STALL
      |-> digitalOutTwo == ($past(driveStatus.ovStall, 2) ^ $past(outputInversionMask[1])))
      else $error("over-voltage stall not on output two");

   op_source_sel_a: assert property (
      chkReady && $past(outputOneFunctionCode) == output_select_pkg::FN_OP_SOURCE
      |-> digitalOutOne == (($past(runCommandSourceSetting, 2) != 8'h00)
                            ^ $past(outputInversionMask[0])))
      else $error("operation source indication wrong");

   direction_sel_a: assert property (
      chkReady && $past(outputOneFunctionCode) == output_select_pkg::FN_REV_CMD
      && !$past(outputInversionMask[0])
      |-> digitalOutOne == !$past(driveStatus.dirForward, 2))
      else $error("reverse command indication wrong");

   freq_ge_sel_a: assert property (
      chkReady && $past(outputOneFunctionCode) == output_select_pkg::FN_FREQ_GE
      && !$past(outputInversionMask[0])
      |-> digitalOutOne == ($past(actualFrequency, 2) >= $past(frequencyThresholdSetting, 2)))
      else $error("frequency at or above threshold wrong");

   freq_lt_sel_a: assert property (
      chkReady && $past(outputTwoFunctionCode) == output_select_pkg::FN_FREQ_LT
      && !$past(outputInversionMask[1])
      |-> digitalOutTwo == ($past(actualFrequency, 2) < $past(frequencyThresholdSetting, 2)))
      else $error("frequency below threshold wrong");

   zero_run_sel_a: assert property (
      chkReady && $past(outputOneFunctionCode) == output_select_pkg::FN_ZERO_RUN
      && !$past(outputInversionMask[0]) && !$past(driveStatus.running, 2)
      |-> !digitalOutOne)
      else $error("zero speed asserted while stopped");

   zero_stop_sel_a: assert property (
      chkReady && $past(outputOneFunctionCode) == output_select_pkg::FN_ZERO_STOP
      && !$past(outputInversionMask[0]) && !$past(driveStatus.running, 2)
      |-> digitalOutOne)
      else $error("zero speed including stop missing");

   err_sel_a: assert property (
      chkReady && $past(outputThreeFunctionCode) == output_select_pkg::FN_ERR_THREE
      |-> digitalOutThree == ($past(driveStatus.errSel[2], 2) ^ $past(outputInversionMask[2])))
      else $error("error selection three not on output three");

   speed_reached_a: assert property (
      chkReady && $past(outputOneFunctionCode) == output_select_pkg::FN_SPEED_REACHED
      && !$past(outputInversionMask[0])
      |-> digitalOutOne == ($past(driveStatus.freqReached, 2) || !$past(driveStatus.running, 2)))
      else $error("speed reached indication wrong");

   motor_slow_a: assert property (
      chkReady && $past(outputFourFunctionCode) == output_select_pkg::FN_MOTOR_SLOW
      && !$past(outputInversionMask[3])
      |-> digitalOutFour == ($past(actualMotorSpeed, 2) < $past(motorSpeedThresholdSetting, 2)))
      else $error("motor speed detection wrong");

   decel_backup_a: assert property (
      chkReady && $past(outputOneFunctionCode) == output_select_pkg::FN_DECEL_BACKUP
      |-> digitalOutOne == ($past(driveStatus.decelBackup, 2) ^ $past(outputInversionMask[0])))
      else $error("backup event not forwarded");

   canopen_map_a: assert property (
      chkReady && $past(canWrEn, 2) && !$past(canWrEn)
      && $past(outputTwoFunctionCode) == output_select_pkg::FN_CANOPEN
      |-> digitalOutTwo == ($past(canWrData[1], 2) ^ $past(outputInversionMask[1])))
      else $error("CANopen bit one not on output two");

   serial_map_a: assert property (
      chkReady && $past(serWrEn && serHit, 2) && !$past(serWrEn && serHit)
      && $past(outputFourFunctionCode) == output_select_pkg::FN_SERIAL
      |-> digitalOutFour == ($past(serWrData[3], 2) ^ $past(outputInversionMask[3])))
      else $error("serial word bit three not on output four");

   fwd_run_a: assert property (
      chkReady && $past(outputOneFunctionCode) == output_select_pkg::FN_FWD_RUN
      && !$past(outputInversionMask[0])
      |-> digitalOutOne == ($past(driveStatus.running, 2) && $past(driveStatus.dirForward, 2)))
      else $error("forward run status wrong");

   rev_run_a: assert property (
      chkReady && $past(outputTwoFunctionCode) == output_select_pkg::FN_REV_RUN
      && !$past(outputInversionMask[1])
      |-> digitalOutTwo == ($past(driveStatus.running, 2) && !$past(driveStatus.dirForward, 2)))
      else $error("reverse run status wrong");

   no_function_a: assert property (
      chkReady && $past(outputThreeFunctionCode) == output_select_pkg::FN_NONE
      |-> digitalOutThree == $past(outputInversionMask[2]))
      else $error("no-function output not idle");

   run_ind_a: assert property (
      chkReady && $past(outputFourFunctionCode) == output_select_pkg::FN_RUN
      |-> digitalOutFour == ($past(driveStatus.running, 2) ^ $past(outputInversionMask[3])))
      else $error("run indication wrong");

   undefined_code_a: assert property (
      chkReady && $past(outputFourFunctionCode) == 8'h02
      |-> digitalOutFour == $past(outputInversionMask[3]))
      else $error("undefined code not idle");

   serial_read_a: assert property (
      serRdEn && serHit && !serWrEn ##1 1'h1 |-> serRdValid && serRdData == $past(serWordQ))
      else $error("serial read data wrong");

   fwd_cmd_sel_a: assert property (
      chkReady && $past(outputTwoFunctionCode) == output_select_pkg::FN_FWD_CMD
      |-> digitalOutTwo == ($past(driveStatus.dirForward, 2) ^ $past(outputInversionMask[1])))
      else $error("forward command wrong");

   zero_run_hit_a: assert property (
      chkReady && $past(outputFourFunctionCode) == output_select_pkg::FN_ZERO_RUN
      |-> digitalOutFour == ($past(outputInversionMask[3]) ^ ($past(driveStatus.running, 2)
          && $past(actualFrequency, 2) == 16'h0000)))
      else $error("zero speed in run wrong");

   zero_stop_hit_a: assert property (
      chkReady && $past(outputTwoFunctionCode) == output_select_pkg::FN_ZERO_STOP
      |-> digitalOutTwo == ($past(outputInversionMask[1]) ^ (!$past(driveStatus.running, 2)
          || $past(actualFrequency, 2) == 16'h0000)))
      else $error("zero speed or stop wrong");

   err_sel_one_a: assert property (
      chkReady && $past(outputOneFunctionCode) == output_select_pkg::FN_ERR_ONE
      |-> digitalOutOne == ($past(driveStatus.errSel[0], 2) ^ $past(outputInversionMask[0])))
      else $error("error selection one wrong");

   err_sel_two_a: assert property (
      chkReady && $past(outputTwoFunctionCode) == output_select_pkg::FN_ERR_TWO
      |-> digitalOutTwo == ($past(driveStatus.errSel[1], 2) ^ $past(outputInversionMask[1])))
      else $error("error selection two wrong");

   err_sel_four_a: assert property (
      chkReady && $past(outputFourFunctionCode) == output_select_pkg::FN_ERR_FOUR
      |-> digitalOutFour == ($past(driveStatus.errSel[3], 2) ^ $past(outputInversionMask[3])))
      else $error("error selection four wrong");

   motor_slow_one_a: assert property (
      chkReady && $past(outputOneFunctionCode) == output_select_pkg::FN_MOTOR_SLOW
      |-> digitalOutOne == ($past(outputInversionMask[0])
          ^ ($past(actualMotorSpeed, 2) < $past(motorSpeedThresholdSetting, 2))))
      else $error("motor speed on output one wrong");

   freq_ge_three_a: assert property (
      chkReady && $past(outputThreeFunctionCode) == output_select_pkg::FN_FREQ_GE
      |-> digitalOutThree == ($past(outputInversionMask[2])
          ^ ($past(actualFrequency, 2) >= $past(frequencyThresholdSetting, 2))))
      else $error("frequency on output three wrong");

   decel_backup_four_a: assert property (
      chkReady && $past(outputFourFunctionCode) == output_select_pkg::FN_DECEL_BACKUP
      |-> digitalOutFour == ($past(driveStatus.decelBackup, 2) ^ $past(outputInversionMask[3])))
      else $error("backup event not on output four");

   can_read_a: assert property (
      chkReady && $past(canWrEn, 2) |-> canRdData == $past(canWrData, 2))
      else $error("object readback wrong");

   ser_valid_a: assert property (
      chkReady |-> serRdValid == $past(serRdEn))
      else $error("read valid misplaced");

   stray_read_a: assert property (
      serRdEn && !serHit ##1 1'h1 |-> serRdData == 16'h0000)
      else $error("unmapped read not zero");

   stray_write_a: assert property (
      serWrEn && !serHit |=> serWordQ == $past(serWordQ))
      else $error("unmapped write taken");

endmodule

/* logic/override_word_reg.sv */
// Writable override word with its own reset value
`timescale 1ns/1ps
module override_word_reg #(
   parameter int              W   = 16,
   parameter logic [W-1:0]    RST = '0
) (
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          nrst,
   // Write port
   input  wire logic          wrEn,
   input  wire logic [W-1:0]  wrData,
   // Stored word
   output logic [W-1:0]       word_q
);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         word_q <= RST;
      end else if (wrEn) begin
         word_q <= wrData;
      end
   end

endmodule
